// [pdfc_top.sv]
// Serial-loaded configuration, aux power-down timing and main fast-lock timer
`timescale 1ns/1ns
module pdfc_top (
    // Clock at the comparison rate and synchronous reset
    input wire logic ref_clk,
    input wire logic rst,
    // Three-wire serial port
    input wire logic ser_data,
    input wire logic ser_clk,
    input wire logic ser_le,
    // Aux pump status and power-down mode bit
    input wire logic aux_pump_active,
    input wire logic aux_pump_powerdown_mode,
    // Auxiliary loop settings
    output pdfc_pkg::pdfc_aux_cfg_t aux_cfg,
    output logic aux_pump_gain,
    output logic aux_power_down,
    output logic aux_pump_hiz,
    output logic [pdfc_pkg::AUX_R_W-1:0] aux_ref_div,
    // Main loop settings
    output logic [pdfc_pkg::MAIN_GAIN_W-1:0] main_pump_gain,
    output logic [pdfc_pkg::PUMP_UA_W-1:0] main_pump_current_ua,
    output pdfc_pkg::pdfc_fl_cfg_t fl_cfg,
    output logic main_fast_lock_active,
    // Fast-lock pin as output and enable
    output logic main_fast_lock_pin,
    output logic main_fast_lock_pin_oe
);
    import pdfc_pkg::*;

    typedef enum logic [3:0] {
        PDFC_PIN_HIZ = 4'h1,
        PDFC_PIN_LOW = 4'h2,
        PDFC_PIN_HIGH = 4'h4,
        PDFC_PIN_FL = 4'h8
    } pdfc_pin_t;

    logic [WORD_W-1:0] shift_r;
    logic sclk_q_r;
    logic le_q_r;
    logic le_rise;
    logic [CODE_W-1:0] code;
    logic load_aux;
    logic load_ref;
    logic load_fl;
    logic [FL_CNT_W-1:0] fl_cnt_r;
    logic [FL_CNT_W-1:0] fl_cnt_nxt;
    logic [TOC_W-1:0] toc_new;
    pdfc_pin_t pin_mode;

    // Serial pins are sampled on ref_clk; a clock edge acts on the first ref_clk edge that sees the pin high
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sclk_q_r <= 1'b0;
            le_q_r <= 1'b0;
        end else begin
            sclk_q_r <= ser_clk;
            le_q_r <= ser_le;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            shift_r <= WORD_RST;
        end else if (ser_clk && !sclk_q_r) begin
            shift_r <= {shift_r[WORD_W-2:0], ser_data};
        end
    end

    assign le_rise = ser_le && !le_q_r;
    assign code = shift_r[CODE_W-1:0];
    // Unknown codes (other loop, test mux) fall through untouched
    assign load_aux = le_rise && (code == CODE_AUX_FB);
    assign load_ref = le_rise && (code == CODE_AUX_REF);
    assign load_fl = le_rise && (code == CODE_MAIN_FL);
    assign toc_new = shift_r[TOC_LSB +: TOC_W];

    // Auxiliary feedback word; ratio legality is left to the host
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            aux_cfg <= '0;
            aux_pump_gain <= 1'b0;
        end else if (load_aux) begin
            aux_cfg.power_down_req <= shift_r[AUX_PD_POS];
            aux_cfg.presc_16 <= shift_r[AUX_PRESC_POS];
            aux_cfg.pump_gain_high <= shift_r[AUX_GAIN_POS];
            aux_cfg.n_div <= shift_r[AUX_N_LSB +: AUX_N_W];
            aux_pump_gain <= shift_r[AUX_GAIN_POS];
        end
    end

    // Power-down: immediate in mode 1, else waits for the pump to go idle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            aux_power_down <= 1'b0;
            aux_pump_hiz <= 1'b0;
        end else if (!aux_cfg.power_down_req) begin
            aux_power_down <= 1'b0;
            aux_pump_hiz <= 1'b0;
        end else if (aux_pump_powerdown_mode || !aux_pump_active) begin
            aux_power_down <= 1'b1;
            aux_pump_hiz <= 1'b1;
        end
    end

    // Reference divider and steady main pump gain
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            aux_ref_div <= AUX_R_W'(0);
            main_pump_gain <= MAIN_GAIN_W'(0);
            main_pump_current_ua <= PUMP_UA_RST;
        end else if (load_ref) begin
            aux_ref_div <= shift_r[AUX_R_LSB +: AUX_R_W];
            main_pump_gain <= shift_r[MAIN_GAIN_LSB +: MAIN_GAIN_W];
            main_pump_current_ua <= PUMP_UA_W'(PUMP_STEP_UA
                * (int'(shift_r[MAIN_GAIN_LSB +: MAIN_GAIN_W]) + 1));
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fl_cfg <= '0;
        end else if (load_fl) begin
            fl_cfg.slip_reduction_select <= shift_r[SLIP_LSB +: 2];
            fl_cfg.main_fast_pump_current <= shift_r[FAST_CUR_LSB +: 4];
            fl_cfg.main_lock_timeout <= toc_new;
        end
    end

    // Timed fast-lock: a write starts a period of twice the timeout, in cycles
    always_comb begin
        fl_cnt_nxt = fl_cnt_r;
        if (load_fl) begin
            if (toc_new >= TOC_TIMED_MIN) begin
                fl_cnt_nxt = FL_CNT_W'(int'(toc_new) * FL_PERIOD_MULT);
            end else begin
                fl_cnt_nxt = FL_CNT_W'(0);
            end
        end else if (fl_cnt_r != FL_CNT_W'(0)) begin
            fl_cnt_nxt = fl_cnt_r - FL_CNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fl_cnt_r <= FL_CNT_W'(0);
        end else begin
            fl_cnt_r <= fl_cnt_nxt;
        end
    end

    // Manual mode holds fast-lock on with no expiry
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            main_fast_lock_active <= 1'b0;
        end else if (load_fl) begin
            main_fast_lock_active <= (toc_new == TOC_MANUAL)
                || (toc_new >= TOC_TIMED_MIN);
        end else if (fl_cfg.main_lock_timeout != TOC_MANUAL) begin
            main_fast_lock_active <= (fl_cnt_nxt != FL_CNT_W'(0));
        end
    end

    always_comb begin
        case (fl_cfg.main_lock_timeout)
            TOC_HIZ: pin_mode = PDFC_PIN_HIZ;
            TOC_MANUAL: pin_mode = PDFC_PIN_LOW;
            TOC_LOW: pin_mode = PDFC_PIN_LOW;
            TOC_HIGH: pin_mode = PDFC_PIN_HIGH;
            default: pin_mode = PDFC_PIN_FL;
        endcase
    end

    // Pin is registered, so it trails the mode and the active flag by a cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            main_fast_lock_pin <= 1'b0;
            main_fast_lock_pin_oe <= 1'b0;
        end else begin
            case (pin_mode)
                PDFC_PIN_HIZ: begin
                    main_fast_lock_pin <= 1'b0;
                    main_fast_lock_pin_oe <= 1'b0;
                end
                PDFC_PIN_LOW: begin
                    main_fast_lock_pin <= 1'b0;
                    main_fast_lock_pin_oe <= 1'b1;
                end
                PDFC_PIN_HIGH: begin
                    main_fast_lock_pin <= 1'b1;
                    main_fast_lock_pin_oe <= 1'b1;
                end
                PDFC_PIN_FL: begin
                    main_fast_lock_pin <= main_fast_lock_active;
                    main_fast_lock_pin_oe <= 1'b1;
                end
                default: begin
                    main_fast_lock_pin <= 1'b0;
                    main_fast_lock_pin_oe <= 1'b0;
                end
            endcase
        end
    end

    // Checks
    // Helper for the checks: length of the current run, so that every timeout
    // is covered and not only the shortest one
    logic [FL_CNT_W-1:0] run_len_r;
    logic [FL_CNT_W-1:0] run_goal_r;
    logic timed_cfg;

    assign timed_cfg = (fl_cfg.main_lock_timeout >= TOC_TIMED_MIN);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            run_goal_r <= FL_CNT_W'(0);
        end else if (load_fl) begin
            run_goal_r <= FL_CNT_W'(int'(toc_new) * FL_PERIOD_MULT);
        end
    end

    // Wraps in manual mode; the checks only look at it in timed settings
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            run_len_r <= FL_CNT_W'(0);
        end else if (load_fl) begin
            run_len_r <= FL_CNT_W'(0);
        end else if (main_fast_lock_active) begin
            run_len_r <= run_len_r + FL_CNT_W'(1);
        end
    end

    sequence s_load_toc4;
        load_fl && (toc_new == TOC_TIMED_MIN);
    endsequence

    sequence s_fl_eight;
        main_fast_lock_active [*8] ##1 !main_fast_lock_active;
    endsequence

    a_gain_follows_word: assert property (@(posedge ref_clk) disable iff (rst)
        load_aux |=> aux_pump_gain == $past(shift_r[AUX_GAIN_POS]))
        else $error("aux pump gain not taken from word");

    a_presc_follows_word: assert property (@(posedge ref_clk) disable iff (rst)
        load_aux |=> aux_cfg.presc_16 == $past(shift_r[AUX_PRESC_POS]))
        else $error("prescaler select not taken from word");

    a_pd_clears_hiz: assert property (@(posedge ref_clk) disable iff (rst)
        (aux_power_down == aux_pump_hiz)
        and (!aux_cfg.power_down_req |=> !aux_power_down))
        else $error("aux power-down and high-Z disagree");

    a_pd_waits_pump: assert property (@(posedge ref_clk) disable iff (rst)
        (!aux_power_down && aux_pump_active && !aux_pump_powerdown_mode)
        |=> !aux_power_down)
        else $error("power-down applied while pump busy");

    a_pd_at_once: assert property (@(posedge ref_clk) disable iff (rst)
        (aux_cfg.power_down_req && aux_pump_powerdown_mode) |=> aux_power_down)
        else $error("immediate power-down missed");

    a_ref_div_load: assert property (@(posedge ref_clk) disable iff (rst)
        load_ref |=> aux_ref_div == $past(shift_r[AUX_R_LSB +: AUX_R_W]))
        else $error("reference ratio not loaded");

    a_pump_current_map: assert property (@(posedge ref_clk) disable iff (rst)
        int'(main_pump_current_ua) == PUMP_STEP_UA * (int'(main_pump_gain) + 1))
        else $error("main pump current does not match gain");

    a_disabled_no_fl: assert property (@(posedge ref_clk) disable iff (rst)
        (load_fl && toc_new != TOC_MANUAL && toc_new < TOC_TIMED_MIN)
        |=> !main_fast_lock_active)
        else $error("fast-lock on in a disabled setting");

    a_pin_gp_modes: assert property (@(posedge ref_clk) disable iff (rst)
        (fl_cfg.main_lock_timeout == TOC_HIZ |=> !main_fast_lock_pin_oe)
        and (fl_cfg.main_lock_timeout == TOC_HIGH |=> main_fast_lock_pin_oe
            && main_fast_lock_pin))
        else $error("general purpose pin level wrong");

    a_manual_holds: assert property (@(posedge ref_clk) disable iff (rst)
        (load_fl && toc_new == TOC_MANUAL) |=> main_fast_lock_active [*8])
        else $error("manual fast-lock dropped");

    a_timed_period: assert property (@(posedge ref_clk) disable iff (rst)
        s_load_toc4 |=> main_fast_lock_active [*8])
        else $error("timed fast-lock too short");

    a_timed_ends: assert property (@(posedge ref_clk) disable iff (rst)
        s_load_toc4 |=> s_fl_eight)
        else $error("timed fast-lock did not end");

    a_run_length: assert property (@(posedge ref_clk) disable iff (rst)
        (timed_cfg && $fell(main_fast_lock_active)) |-> run_len_r == run_goal_r)
        else $error("timed fast-lock length is not twice the timeout");

    a_run_bounded: assert property (@(posedge ref_clk) disable iff (rst)
        (timed_cfg && !load_fl && main_fast_lock_active) |-> run_len_r < run_goal_r)
        else $error("timed fast-lock outlived its period");

    a_pin_follows: assert property (@(posedge ref_clk) disable iff (rst)
        timed_cfg |=> main_fast_lock_pin_oe
            && main_fast_lock_pin == $past(main_fast_lock_active))
        else $error("fast-lock pin does not follow the state");
endmodule

// [pdfc_pkg.sv]
// Package for the synthesizer divider, pump gain and fast-lock configuration block
// Overview of operation
// - Aux gain bit: 0 is 1 mA, 1 is 4 mA
// - Prescaler bit: 0 is 8/9, 1 is 16/17
// - Aux power-down bit stops loop, pump high-Z
// - Mode 0: power-down waits for idle pump
// - Mode 1: power-down applies at once
// - Aux reference ratio 15 bits, 3 to 32767
// - Main pump current is 100 times (k+1) uA
// - Timeout 0, 2 and 3 disable fast-lock circuitry
// - Timeout 0 high-Z, 2 low, 3 high
// - Timeout 1 drives low, forces fast-lock on
// - Timeout 4 and up runs timed fast-lock
// - Fast-lock lasts twice the timeout value, cycles
package pdfc_pkg;
    localparam int WORD_W = 24;
    localparam int CODE_W = 4;
    // Destination codes in the low nibble of each word
    localparam logic [3:0] CODE_AUX_FB = 4'h3;
    localparam logic [3:0] CODE_AUX_REF = 4'h5;
    localparam logic [3:0] CODE_MAIN_FL = 4'h7;
    // Auxiliary feedback divider word
    localparam int AUX_PD_POS = 23;
    localparam int AUX_PRESC_POS = 22;
    localparam int AUX_GAIN_POS = 21;
    localparam int AUX_N_LSB = 4;
    localparam int AUX_N_W = 17;
    // Auxiliary reference and main pump gain word
    localparam int MAIN_GAIN_LSB = 19;
    localparam int MAIN_GAIN_W = 4;
    localparam int AUX_R_LSB = 4;
    localparam int AUX_R_W = 15;
    // Main fast-lock word
    localparam int SLIP_LSB = 22;
    localparam int FAST_CUR_LSB = 18;
    localparam int TOC_LSB = 4;
    localparam int TOC_W = 14;
    localparam int FL_CNT_W = 15;
    localparam logic [13:0] TOC_HIZ = 14'h0000;
    localparam logic [13:0] TOC_MANUAL = 14'h0001;
    localparam logic [13:0] TOC_LOW = 14'h0002;
    localparam logic [13:0] TOC_HIGH = 14'h0003;
    localparam logic [13:0] TOC_TIMED_MIN = 14'h0004;
    localparam int FL_PERIOD_MULT = 2;
    localparam int PUMP_STEP_UA = 100;
    localparam int PUMP_UA_W = 11;
    // Reset values
    localparam logic [23:0] WORD_RST = 24'h000000;
    localparam logic [10:0] PUMP_UA_RST = 11'h064;

    typedef struct packed {
        logic power_down_req;
        logic presc_16;
        logic pump_gain_high;
        logic [AUX_N_W-1:0] n_div;
    } pdfc_aux_cfg_t;

    typedef struct packed {
        logic [1:0] slip_reduction_select;
        logic [3:0] main_fast_pump_current;
        logic [TOC_W-1:0] main_lock_timeout;
    } pdfc_fl_cfg_t;
endpackage

// [pdfc_host.sv]
// Host model that shifts configuration words into the serial port
`timescale 1ns/1ns
module pdfc_host (
    // Clock
    input wire logic ref_clk,
    // Serial port
    output logic ser_data,
    output logic ser_clk,
    output logic ser_le
);
    import pdfc_pkg::*;
    initial begin
        ser_data = 1'b0;
        ser_clk = 1'b0;
        ser_le = 1'b0;
    end
    // A careful host never sends a prohibited ratio
    function automatic bit legal(input logic [23:0] w);
        int n;
        int p;
        n = int'(w[20:4]);
        p = w[22] ? 16 : 8;
        if (w[3:0] == CODE_AUX_FB)
            return n / p >= 3 && n / p >= n % p && (w[22] || !w[7]);
        if (w[3:0] == CODE_AUX_REF)
            return w[18:4] >= 15'h0003;
        return 1'b1;
    endfunction
    // h is the number of cycles each clock level stands: 2 is prompt, more is slow
    task automatic send(input logic [23:0] w, input int h);
        if (!legal(w))
            return;
        for (int i = 23; i >= 0; i--) begin
            @(negedge ref_clk);
            ser_clk = 1'b0;
            ser_data = w[i];
            repeat (h) @(negedge ref_clk);
            ser_clk = 1'b1;
            repeat (h - 1) @(negedge ref_clk);
        end
        @(negedge ref_clk);
        ser_clk = 1'b0;
        ser_le = 1'b1;
        repeat (h) @(negedge ref_clk);
        ser_le = 1'b0;
        // Released data line must not keep showing the last bit
        ser_data = ~ser_data;
    endtask
endmodule

// [pll_divider_fastlock_config_bench.sv]
// Self-checking bench for the serial configuration and fast-lock block
`timescale 1ns/1ns
module pll_divider_fastlock_config_bench;
    import pdfc_pkg::*;
    logic ref_clk, rst, ser_data, ser_clk, ser_le, pump_act, pd_mode;
    pdfc_aux_cfg_t aux_cfg;
    pdfc_fl_cfg_t fl_cfg;
    logic aux_gain, aux_pd, aux_hiz, fl_act, fl_pin, fl_oe;
    logic [AUX_R_W-1:0] ref_div;
    logic [MAIN_GAIN_W-1:0] m_gain;
    logic [PUMP_UA_W-1:0] m_ua;
    int fail_count = 0;
    int cmp_count = 0;
    int act_cnt = 0;
    int pin_cnt = 0;
    pdfc_host host (.ref_clk(ref_clk), .ser_data(ser_data), .ser_clk(ser_clk), .ser_le(ser_le));
    pdfc_top uut (.ref_clk(ref_clk), .rst(rst), .ser_data(ser_data), .ser_clk(ser_clk),
        .ser_le(ser_le), .aux_pump_active(pump_act), .aux_pump_powerdown_mode(pd_mode),
        .aux_cfg(aux_cfg), .aux_pump_gain(aux_gain), .aux_power_down(aux_pd),
        .aux_pump_hiz(aux_hiz), .aux_ref_div(ref_div), .main_pump_gain(m_gain),
        .main_pump_current_ua(m_ua), .fl_cfg(fl_cfg), .main_fast_lock_active(fl_act),
        .main_fast_lock_pin(fl_pin), .main_fast_lock_pin_oe(fl_oe));
    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (fl_act === 1'b1)
            act_cnt <= act_cnt + 1;
        if (fl_pin === 1'b1)
            pin_cnt <= pin_cnt + 1;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    // Settle margin covers the load edge plus the extra cycle of the pin
    task automatic load(input logic [23:0] w, input int h);
        host.send(w, h);
        repeat (3) @(negedge ref_clk);
    endtask
    function automatic logic [23:0] fb(input logic pd, input logic p16, input logic g, input int n);
        return {pd, p16, g, 17'(n), CODE_AUX_FB};
    endfunction
    task automatic t_reset();
        chk("aux_cfg", 32'(aux_cfg), 32'h0);
        chk("pump_ua", 32'(m_ua), 32'h64);
        chk("pin_oe", 32'(fl_oe), 32'h0);
        $display("test reset done");
    endtask
    task automatic t_aux_fb();
        load(fb(1'b0, 1'b1, 1'b1, 240), 2);
        chk("aux_cfg", 32'(aux_cfg), 32'h0006_00F0);
        chk("aux_gain", 32'(aux_gain), 32'h1);
        load(fb(1'b0, 1'b0, 1'b0, 48), 4);
        chk("aux_cfg", 32'(aux_cfg), 32'h0000_0030);
        chk("aux_gain", 32'(aux_gain), 32'h0);
        $display("test aux_fb done");
    endtask
    task automatic t_gain();
        logic [14:0] r;
        for (int k = 0; k < 16; k++) begin
            r = k[0] ? 15'h7FFF : 15'h0003;
            load({1'b0, 4'(k), r, CODE_AUX_REF}, 2);
            chk("main_gain", 32'(m_gain), 32'(k));
            chk("pump_ua", 32'(m_ua), 32'(PUMP_STEP_UA * (k + 1)));
            chk("ref_div", 32'(ref_div), 32'(r));
        end
        load({20'hFFFFF, 4'h9}, 2);
        chk("main_gain", 32'(m_gain), 32'hF);
        chk("ref_div", 32'(ref_div), 32'h7FFF);
        chk("aux_cfg", 32'(aux_cfg), 32'h0000_0030);
        $display("test gain done");
    endtask
    task automatic t_pd();
        pump_act = 1'b1;
        pd_mode = 1'b0;
        load(fb(1'b1, 1'b0, 1'b0, 48), 2);
        repeat (4) @(negedge ref_clk);
        chk("aux_pd", 32'(aux_pd), 32'h0);
        pump_act = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk("aux_pd", 32'(aux_pd), 32'h1);
        chk("aux_hiz", 32'(aux_hiz), 32'h1);
        load(fb(1'b0, 1'b0, 1'b0, 48), 2);
        chk("aux_hiz", 32'(aux_hiz), 32'h0);
        pump_act = 1'b1;
        pd_mode = 1'b1;
        load(fb(1'b1, 1'b0, 1'b0, 48), 2);
        chk("aux_pd", 32'(aux_pd), 32'h1);
        $display("test power_down done");
    endtask
    task automatic t_fl();
        logic [13:0] tv [4] = '{14'h1, 14'h2, 14'h3, 14'h0};
        logic [2:0] ex [4] = '{3'b011, 3'b010, 3'b110, 3'b000};
        for (int i = 0; i < 4; i++) begin
            load({6'h00, tv[i], CODE_MAIN_FL}, 2);
            repeat (20) @(negedge ref_clk);
            chk("pin_oe", 32'(fl_oe), 32'(ex[i][1]));
            chk("fl_act", 32'(fl_act), 32'(ex[i][0]));
            if (ex[i][1])
                chk("pin", 32'(fl_pin), 32'(ex[i][2]));
        end
        for (int t = 4; t < 6; t++) begin
            act_cnt = 0;
            pin_cnt = 0;
            load({2'h2, 4'h5, 14'(t), CODE_MAIN_FL}, t - 2);
            repeat (30) @(negedge ref_clk);
            chk("fl_cfg", 32'(fl_cfg), {12'h0, 2'h2, 4'h5, 14'(t)});
            chk("fl_cycles", 32'(act_cnt), 32'(FL_PERIOD_MULT * t));
            chk("pin_cycles", 32'(pin_cnt), 32'(FL_PERIOD_MULT * t));
            chk("pin_oe", 32'(fl_oe), 32'h1);
            chk("pin", 32'(fl_pin), 32'h0);
        end
        $display("test fast_lock done");
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        pump_act = 1'b0;
        pd_mode = 1'b0;
        repeat (5) @(negedge ref_clk);
        rst = 1'b0;
        t_reset();
        t_aux_fb();
        t_gain();
        t_pd();
        t_fl();
        end_of_test();
    end
    // About 3,150 cycles are expected; far beyond that means a hang
    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        end_of_test();
    end
endmodule
